// [design/bridge_status_word_reporter.sv]
// Status word builder and serial output path of the half-bridge driver
`timescale 1ns/10ps

// How it works
// RULE1: Group select of previous accepted command picks bridges 12..7 (1) or 6..1 (0).
// RULE2: Pseudo-bit ahead of bit 15 carries the latched global thermal shutdown flag.
// RULE3: Bit 15 is the latched overcurrent flag of the selected group.
// RULE4: Bit 14 is high while either driver supply is under or over voltage.
// RULE5: Bit 13 is the latched underload flag of the selected group.
// RULE6: Bits 12..1 hold six two-bit bridge fields, highest bridge in 12:11.
// RULE7: Field codes: 00 disabled, 01 overcurrent, 10 underload, 11 enabled.
// RULE8: Each field shows one condition, chosen by priority.
// RULE9: Bit 0 follows the thermal warning condition.
// RULE10: Power-on reset clears the whole status word and the pseudo-bit; the code clears latches and shifter; bits 14 and 0 follow live inputs.
// RULE11: Pseudo-bit drives serial out from select fall to first rising clock.
// RULE12: Status shifts out MSB first on each rising serial clock.
// RULE13: Serial out released whenever chip select goes high.
// RULE14: Pseudo-bit is thermal shutdown ORed with serial in, for chaining.
// RULE15: Full status word captured into the shifter when chip select falls.
module bridge_status_word_reporter (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic chipSelectN,
  input wire logic serialClk,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEn,
  input wire logic channelGroupSelect,
  input wire logic statusResetPulse,
  input wire logic [bridge_status_pkg::NUM_BRIDGES-1:0] overcurrentEvent,
  input wire logic [bridge_status_pkg::NUM_BRIDGES-1:0] underloadEvent,
  input wire logic [bridge_status_pkg::NUM_BRIDGES-1:0] bridgeDriveOn,
  input wire logic thermalShutdownEvent,
  input wire logic supplyFaultLevel,
  input wire logic thermalWarningLevel,
  output logic thermalShutdownLatched,
  output logic [bridge_status_pkg::NUM_BRIDGES-1:0] overcurrentShutdownFlag,
  output logic [bridge_status_pkg::NUM_BRIDGES-1:0] underloadFlag
);

  localparam int NB = bridge_status_pkg::NUM_BRIDGES;
  localparam int GS = bridge_status_pkg::GROUP_SIZE;
  localparam int FW = bridge_status_pkg::FIELD_W;
  localparam int WW = bridge_status_pkg::WORD_W;

  // Whole module state in one record
  typedef struct packed {
    logic [1:0] csSync;
    logic [1:0] clkSync;
    logic [1:0] siSync;
    logic csPrev;
    logic clkPrev;
    logic siSample;
    logic [WW-1:0] shiftWord;
    bridge_status_pkg::link_state_e linkState;
    logic soBit;
    logic soEn;
    logic thermLatch;
    logic [NB-1:0] ocLatch;
    logic [NB-1:0] ulLatch;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  logic [FW-1:0] bridgeOutputState [NB];
  logic [WW-1:0] upperWord;
  logic [WW-1:0] lowerWord;
  logic [WW-1:0] selectedWord;
  logic [NB-1:0] groupClear;
  logic csLevel;
  logic clkLevel;
  logic siLevel;
  logic csFall;
  logic csRise;
  logic clkRise;
  logic clkFall;

  // Only the second synchroniser stage is ever looked at
  assign csLevel = s_r.csSync[1];
  assign clkLevel = s_r.clkSync[1];
  assign siLevel = s_r.siSync[1];
  assign csFall = s_r.csPrev & ~csLevel;
  assign csRise = ~s_r.csPrev & csLevel;
  assign clkRise = ~s_r.clkPrev & clkLevel;
  assign clkFall = s_r.clkPrev & ~clkLevel;

  // Per-bridge priority encoding and status reset scope
  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++) begin : g_bridge
      // Overcurrent outranks underload, so an underload behind it stays hidden
      always_comb begin
        if (s_r.ocLatch[gi]) begin
          bridgeOutputState[gi] = bridge_status_pkg::HB_OVERCURRENT; // see RULE8 see RULE7
        end else if (s_r.ulLatch[gi]) begin
          bridgeOutputState[gi] = bridge_status_pkg::HB_UNDERLOAD; // see RULE7
        end else if (bridgeDriveOn[gi]) begin
          bridgeOutputState[gi] = bridge_status_pkg::HB_ENABLED;
        end else begin
          bridgeOutputState[gi] = bridge_status_pkg::HB_DISABLED;
        end
      end
      // Reset request clears only the group that is selected
      assign groupClear[gi] = statusResetPulse & ((gi >= GS) == (channelGroupSelect == bridge_status_pkg::GROUP_UPPER));
    end
  endgenerate

  // Field packing, highest bridge of a group in the top field
  generate
    for (gi = 0; gi < GS; gi++) begin : g_field
      assign upperWord[bridge_status_pkg::FIELD_LSB + FW*gi +: FW] = bridgeOutputState[GS + gi]; // see RULE6
      assign lowerWord[bridge_status_pkg::FIELD_LSB + FW*gi +: FW] = bridgeOutputState[gi]; // see RULE6
    end
  endgenerate

  // Group summary flags and global flags
  assign upperWord[bridge_status_pkg::OVERCURRENT_BIT] = |s_r.ocLatch[NB-1:GS]; // see RULE3
  assign lowerWord[bridge_status_pkg::OVERCURRENT_BIT] = |s_r.ocLatch[GS-1:0]; // see RULE3
  assign upperWord[bridge_status_pkg::SUPPLY_FAULT_BIT] = supplyFaultLevel; // see RULE4
  assign lowerWord[bridge_status_pkg::SUPPLY_FAULT_BIT] = supplyFaultLevel; // see RULE4
  assign upperWord[bridge_status_pkg::UNDERLOAD_BIT] = |s_r.ulLatch[NB-1:GS]; // see RULE5
  assign lowerWord[bridge_status_pkg::UNDERLOAD_BIT] = |s_r.ulLatch[GS-1:0]; // see RULE5
  assign upperWord[bridge_status_pkg::WARNING_BIT] = thermalWarningLevel; // see RULE9
  assign lowerWord[bridge_status_pkg::WARNING_BIT] = thermalWarningLevel; // see RULE9

  // Group select comes from the last accepted command register
  assign selectedWord = (channelGroupSelect == bridge_status_pkg::GROUP_UPPER) ? upperWord : lowerWord; // see RULE1

  // Next-state logic for synchronisers, fault latches and the link
  always_comb begin
    s_nxt = s_r;
    s_nxt.csSync = {s_r.csSync[0], chipSelectN};
    s_nxt.clkSync = {s_r.clkSync[0], serialClk};
    s_nxt.siSync = {s_r.siSync[0], serialIn};
    s_nxt.csPrev = csLevel;
    s_nxt.clkPrev = clkLevel;

    // Latches: a fault arriving with the clear still sets the flag
    // Thermal latch is global, so any status reset clears it whatever the group
    s_nxt.thermLatch = thermalShutdownEvent | (s_r.thermLatch & ~statusResetPulse);
    s_nxt.ocLatch = overcurrentEvent | (s_r.ocLatch & ~groupClear);
    s_nxt.ulLatch = underloadEvent | (s_r.ulLatch & ~groupClear);

    // Frame sequencer
    case (s_r.linkState)
      bridge_status_pkg::LINK_IDLE: begin
        if (csFall) begin
          s_nxt.shiftWord = selectedWord; // see RULE15
          s_nxt.linkState = bridge_status_pkg::LINK_PSEUDO;
        end
      end
      bridge_status_pkg::LINK_PSEUDO: begin
        if (csRise) begin
          s_nxt.linkState = bridge_status_pkg::LINK_IDLE; // see RULE13
        end else if (clkRise) begin
          s_nxt.linkState = bridge_status_pkg::LINK_SHIFT; // see RULE11
        end
      end
      bridge_status_pkg::LINK_SHIFT: begin
        if (csRise) begin
          s_nxt.linkState = bridge_status_pkg::LINK_IDLE; // see RULE13
        end else begin
          // Serial in is taken at the falling edge, moved in at the rising one
          if (clkFall) begin
            s_nxt.siSample = siLevel;
          end
          if (clkRise) begin
            s_nxt.shiftWord = {s_r.shiftWord[WW-2:0], s_r.siSample}; // see RULE12
          end
        end
      end
      default: begin
        s_nxt.linkState = bridge_status_pkg::LINK_IDLE;
      end
    endcase

    // Output pin, registered; chained serial in flows through after 16 bits
    s_nxt.soEn = (s_nxt.linkState != bridge_status_pkg::LINK_IDLE); // see RULE13
    case (s_nxt.linkState)
      bridge_status_pkg::LINK_PSEUDO: begin
        s_nxt.soBit = s_r.thermLatch | siLevel; // see RULE2 see RULE14 see RULE11
      end
      bridge_status_pkg::LINK_SHIFT: begin
        s_nxt.soBit = s_nxt.shiftWord[WW-1]; // see RULE12
      end
      default: begin
        s_nxt.soBit = bridge_status_pkg::FLAG_RESET;
      end
    endcase
  end

  // State register; reset stands for logic supply power-on
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      // Synchronisers start at the idle pin levels, so no false edge follows reset
      s_r.csSync <= 2'h3;
      s_r.clkSync <= 2'h0;
      s_r.siSync <= 2'h0;
      s_r.csPrev <= 1'h1;
      s_r.clkPrev <= 1'h0;
      s_r.siSample <= bridge_status_pkg::FLAG_RESET;
      s_r.shiftWord <= bridge_status_pkg::STATUS_RESET; // see RULE10
      s_r.linkState <= bridge_status_pkg::LINK_IDLE;
      s_r.soBit <= bridge_status_pkg::FLAG_RESET;
      s_r.soEn <= 1'h0;
      s_r.thermLatch <= bridge_status_pkg::FLAG_RESET; // see RULE10
      s_r.ocLatch <= {NB{bridge_status_pkg::FLAG_RESET}}; // see RULE10
      s_r.ulLatch <= {NB{bridge_status_pkg::FLAG_RESET}}; // see RULE10
    end else begin
      s_r <= s_nxt;
    end
  end

  // Pin and fault outputs straight from flops
  assign serialOut = s_r.soBit;
  assign serialOutEn = s_r.soEn;
  assign thermalShutdownLatched = s_r.thermLatch;
  assign overcurrentShutdownFlag = s_r.ocLatch;
  assign underloadFlag = s_r.ulLatch;

endmodule

// [design/bridge_status_pkg.sv]
// Constants and types shared by the half-bridge status word reporter
package bridge_status_pkg;

  // Word and channel geometry
  localparam int WORD_W = 16;
  localparam int NUM_BRIDGES = 12;
  localparam int GROUP_SIZE = 6;
  localparam int FIELD_W = 2;

  // Field positions inside the status word
  localparam int OVERCURRENT_BIT = 15;
  localparam int SUPPLY_FAULT_BIT = 14;
  localparam int UNDERLOAD_BIT = 13;
  localparam int FIELD_LSB = 1;
  localparam int WARNING_BIT = 0;

  // Reset value of every status bit, pseudo-bit included
  localparam logic [WORD_W-1:0] STATUS_RESET = 16'h0000;
  localparam logic FLAG_RESET = 1'h0;

  // Per-bridge state codes
  localparam logic [FIELD_W-1:0] HB_DISABLED = 2'h0;
  localparam logic [FIELD_W-1:0] HB_OVERCURRENT = 2'h1;
  localparam logic [FIELD_W-1:0] HB_UNDERLOAD = 2'h2;
  localparam logic [FIELD_W-1:0] HB_ENABLED = 2'h3;

  // Group select value naming bridges 12..7
  localparam logic GROUP_UPPER = 1'h1;

  // Link sequencer, Gray along idle -> pseudo -> shift
  typedef enum logic [1:0] {
    LINK_IDLE = 2'h0,
    LINK_PSEUDO = 2'h1,
    LINK_SHIFT = 2'h3
  } link_state_e;

endpackage

// [verification/bridge_status_word_reporter_assertions.sv]
// Port checker for the status word reporter
`timescale 1ns/10ps
module bridge_status_checker (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic chipSelectN,
  input wire logic serialOut,
  input wire logic serialOutEn,
  input wire logic channelGroupSelect,
  input wire logic statusResetPulse,
  input wire logic [11:0] overcurrentEvent,
  input wire logic [11:0] underloadEvent,
  input wire logic thermalShutdownEvent,
  input wire logic thermalShutdownLatched,
  input wire logic [11:0] overcurrentShutdownFlag,
  input wire logic [11:0] underloadFlag
);
  // Single domain, so one clocking and reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  AST_THERM_SET: assert property (thermalShutdownEvent |=> thermalShutdownLatched)
    else $error("thermal latch not set");
  AST_THERM_HOLD: assert property (thermalShutdownLatched && !statusResetPulse |=> thermalShutdownLatched)
    else $error("thermal latch lost");
  AST_OC_SET: assert property (|overcurrentEvent |=>
    (overcurrentShutdownFlag & $past(overcurrentEvent)) == $past(overcurrentEvent)) else $error("oc not set");
  AST_OC_CLR: assert property (statusResetPulse && !channelGroupSelect && overcurrentEvent[5:0] == 6'h00 |=>
    overcurrentShutdownFlag[5:0] == 6'h00) else $error("oc not cleared");
  AST_UL_SET: assert property (|underloadEvent |=>
    (underloadFlag & $past(underloadEvent)) == $past(underloadEvent)) else $error("ul not set");
  AST_EN_ON: assert property ($fell(chipSelectN) |-> ##[2:5] serialOutEn) else $error("no drive");
  AST_EN_OFF: assert property ($rose(chipSelectN) |-> ##[2:6] !serialOutEn) else $error("no release");
  AST_SO_IDLE: assert property (!serialOutEn |-> !serialOut) else $error("idle data");
  AST_PSEUDO: assert property ($rose(serialOutEn) |-> serialOut || !$past(thermalShutdownLatched))
    else $error("pseudo lost");
  // Main scenarios reached
  cover property ($rose(serialOutEn) && serialOut);
  cover property (statusResetPulse && |overcurrentShutdownFlag);
  cover property ($rose(chipSelectN));
endmodule

bind bridge_status_word_reporter bridge_status_checker chk (.ref_clk(ref_clk), .rstn(rstn),
  .chipSelectN(chipSelectN), .serialOut(serialOut), .serialOutEn(serialOutEn),
  .channelGroupSelect(channelGroupSelect), .statusResetPulse(statusResetPulse),
  .overcurrentEvent(overcurrentEvent), .underloadEvent(underloadEvent),
  .thermalShutdownEvent(thermalShutdownEvent), .thermalShutdownLatched(thermalShutdownLatched),
  .overcurrentShutdownFlag(overcurrentShutdownFlag), .underloadFlag(underloadFlag));

// [verification/spi_host_model.sv]
// Serial host model that runs status frames
`timescale 1ns/10ps
module spi_host_model (
  output logic chipSelectN,
  output logic serialClk,
  output logic serialIn,
  input wire logic serialOut,
  input wire logic serialOutEn
);
  // Idle: select high, clock and data low
  initial begin
    chipSelectN = 1'h1;
    serialClk = 1'h0;
    serialIn = 1'h0;
  end
  // pre mimics an upstream chained part; a released line reads unknown
  task automatic frame(input logic pre, input logic [15:0] cmd, output logic [16:0] rsp);
    chipSelectN = 1'h0;
    serialIn = pre;
    #62.5 rsp[16] = serialOutEn ? serialOut : 1'hx;
    for (int i = 15; i >= 0; i--) begin
      serialIn = cmd[i];
      serialClk = 1'h1;
      #62.5 rsp[i] = serialOutEn ? serialOut : 1'hx;
      serialClk = 1'h0;
      #62.5;
    end
    serialIn = 1'h0;
    chipSelectN = 1'h1;
    #100;
  endtask
endmodule

// [verification/tb_bridge_status_word_reporter.sv]
// Self-checking bench for the status word reporter
`timescale 1ns/10ps
module tb_bridge_status_word_reporter;
  logic ref_clk = 1'h0, rstn = 1'h0, grp = 1'h0, rp = 1'h0, thermEv = 1'h0, supFault = 1'h0, warnLvl = 1'h0;
  logic thermM = 1'h0;
  logic [11:0] ocEv = 12'h000, ulEv = 12'h000, drv = 12'h000, ocM = 12'h000, ulM = 12'h000, m, ocQ, ulQ;
  logic thermQ, cs, sck, si, so, soEn, pre;
  logic [16:0] rsp;
  int seed = 32'hcaf3, err_count = 0, n_tests = 0;
  always #5 ref_clk = ~ref_clk;
  bridge_status_word_reporter dut (.ref_clk(ref_clk), .rstn(rstn), .chipSelectN(cs), .serialClk(sck),
    .serialIn(si), .serialOut(so), .serialOutEn(soEn), .channelGroupSelect(grp), .statusResetPulse(rp),
    .overcurrentEvent(ocEv), .underloadEvent(ulEv), .bridgeDriveOn(drv), .thermalShutdownEvent(thermEv),
    .supplyFaultLevel(supFault), .thermalWarningLevel(warnLvl), .thermalShutdownLatched(thermQ),
    .overcurrentShutdownFlag(ocQ), .underloadFlag(ulQ));
  spi_host_model host (.chipSelectN(cs), .serialClk(sck), .serialIn(si), .serialOut(so), .serialOutEn(soEn));
  // Expected frame from the bench's own latch copy; fault outranks underload
  function automatic logic [16:0] expWord(input logic g);
    logic [15:0] w;
    int b;
    w = {|(g ? ocM[11:6] : ocM[5:0]), supFault, |(g ? ulM[11:6] : ulM[5:0]), 12'h000, warnLvl};
    for (int k = 0; k < 6; k++) begin
      b = g ? k + 6 : k;
      w[2*k+1 +: 2] = ocM[b] ? bridge_status_pkg::HB_OVERCURRENT : ulM[b] ? bridge_status_pkg::HB_UNDERLOAD :
        drv[b] ? bridge_status_pkg::HB_ENABLED : bridge_status_pkg::HB_DISABLED;
    end
    return {thermM, w};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("mismatches=%0d checks=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog well past the expected run of about 100 us
  initial begin
    #500000;
    err_count++;
    test_done;
  end
  // Random faults, clears colliding with events, random group, a chained pseudo-bit
  initial begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'h1;
    repeat (5) @(posedge ref_clk);
    // Frames start off the clock edge so select never races the sampling flop
    #1;
    host.frame(1'h0, 16'h0000, rsp);
    chk(rsp, 17'h0);
    for (int n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      ocEv <= 12'($random(seed) & $random(seed) & $random(seed));
      ulEv <= 12'($random(seed) & $random(seed));
      thermEv <= ($random(seed) & 7) == 0;
      rp <= ($random(seed) & 3) == 0;
      grp <= 1'($random(seed));
      drv <= 12'($random(seed));
      supFault <= 1'($random(seed));
      warnLvl <= 1'($random(seed));
      // Corner: clear meets fresh faults in the low group, bridge 1 has both faults
      if (n == 5) begin
        ocEv <= 12'h021;
        ulEv <= 12'h003;
        thermEv <= 1'h1;
        rp <= 1'h1;
        grp <= 1'h0;
      end
      @(posedge ref_clk);
      m = grp ? 12'hfc0 : 12'h03f;
      if (rp) begin
        thermM = 1'h0;
        ocM &= ~m;
        ulM &= ~m;
      end
      ocM |= ocEv;
      ulM |= ulEv;
      thermM |= thermEv;
      ocEv <= 12'h000;
      ulEv <= 12'h000;
      thermEv <= 1'h0;
      rp <= 1'h0;
      @(posedge ref_clk);
      #1;
      chk(ocQ, ocM);
      chk(ulQ, ulM);
      chk(thermQ, thermM);
      pre = (n % 8) == 3;
      host.frame(pre, 16'($random(seed)), rsp);
      chk(rsp, expWord(grp) | {pre, 16'h0});
    end
    // Second reset after the random frames must wipe every latch
    @(posedge ref_clk);
    rstn <= 1'h0;
    drv <= 12'h000;
    supFault <= 1'h0;
    warnLvl <= 1'h0;
    thermM = 1'h0;
    ocM = 12'h000;
    ulM = 12'h000;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'h1;
    repeat (5) @(posedge ref_clk);
    #1;
    chk({thermQ, ocQ, ulQ}, 32'h0);
    host.frame(1'h0, 16'h0000, rsp);
    chk(rsp, 17'h0);
    test_done;
  end
endmodule
